// *** hw/prcs_gpio.sv ***
// two gpio ports with reset behaviour, comparator select and ahb-lite registers
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps

module prcs_gpio (
   input  wire logic                    REF_CLK_IN,     // 200 mhz system clock
   input  wire logic                    SYS_RST_IN,     // synchronous reset, high
   input  wire logic                    HSEL_IN,        // ahb slave select
   input  wire logic [31:0]             HADDR_IN,       // ahb byte address
   input  wire logic [1:0]              HTRANS_IN,      // ahb transfer type
   input  wire logic                    HWRITE_IN,      // ahb write
   input  wire logic [2:0]              HSIZE_IN,       // ahb size
   input  wire logic [31:0]             HWDATA_IN,      // ahb write data
   input  wire logic                    HREADY_IN,      // ahb bus ready
   output logic [31:0]                  HRDATA_OUT,     // ahb read data
   output logic                         HREADYOUT_OUT,  // never stalls
   output logic                         HRESP_OUT,      // always okay
   input  wire logic [prcs_pkg::PA_W-1:0] A_PIN_IN,     // port a pin levels
   output logic [prcs_pkg::PA_W-1:0]    A_PIN_OUT,      // port a drive value
   output logic [prcs_pkg::PA_W-1:0]    A_PIN_OE_OUT,   // port a drive enable
   input  wire logic [prcs_pkg::PB_W-1:0] B_PIN_IN,     // port b pin levels
   output logic [prcs_pkg::PB_W-1:0]    B_PIN_OUT,      // port b drive value
   output logic [prcs_pkg::PB_W-1:0]    B_PIN_OE_OUT,   // port b drive enable
   input  wire logic                    CMP_RESULT_IN,  // analog comparator output
   output logic                         CMP_ROUTE_OUT,  // connect b4/b3 to comparator
   output logic                         CMP_POWER_OUT,  // comparator bias enable
   input  wire logic                    HALT_MODE_IN,   // core in halt, same clock
   input  wire logic                    STOP_MODE_IN,   // core in stop, same clock
   input  wire logic                    B4_IRQ_EN_IN,   // b4 interrupt enabled
   output logic [prcs_pkg::PB_W-1:0]    PB_IRQ_SRC_OUT, // interrupt source levels
   output logic                         HALT_WAKE_OUT,  // wake pulse out of halt
   input  wire logic                    LOW_SUPPLY_IN,  // supply monitor trip, async
   output logic                         GLOBAL_RST_OUT  // global reset request
);

   localparam int PA_W = prcs_pkg::PA_W;
   localparam int PB_W = prcs_pkg::PB_W;
   localparam int CI   = prcs_pkg::CMP_IN_BIT;
   localparam int CR   = prcs_pkg::CMP_REF_BIT;

   prcs_pkg::prcs_phase_type    phase_q;
   prcs_pkg::prcs_phase_type    phase_d;
   logic [7:0]                  addr_idx;
   logic                        addr_hit;
   logic                        wr_fire;
   logic [7:0]                  wr_en;
   logic [prcs_pkg::REG_W-1:0]  wdata;
   logic [prcs_pkg::REG_W-1:0]  rd_val;
   logic [31:0]                 rdata_q;
   logic [PA_W-1:0]             outa_q;
   logic [PA_W-1:0]             dira_q;
   logic [PA_W-1:0]             fsela_q;
   logic [PA_W-1:0]             ina_q;
   logic [PB_W-1:0]             outb_q;
   logic [PB_W-1:0]             dirb_q;
   logic [PB_W-1:0]             fselb_q;
   logic [PB_W-1:0]             inb_q;
   logic [PA_W-1:0]             pa_s1_q;
   logic [PA_W-1:0]             pa_s2_q;
   logic [PB_W-1:0]             pb_s1_q;
   logic [PB_W-1:0]             pb_s2_q;
   logic                        cmp_s1_q;
   logic                        cmp_s2_q;
   logic                        cmp_s3_q;
   logic                        cmp_hold_q;
   logic                        lvp_s1_q;
   logic                        lvp_s2_q;
   logic                        full_rst;
   logic                        comp_sel;
   logic                        cmp_now;
   logic [PB_W-1:0]             samp_b;
   logic [PB_W-1:0]             cmp_mask;
   logic [PB_W-1:0]             in_mask_b;

   // full reset is the system reset or a low supply report; stop recovery and
   // watchdog events are not routed here, so they leave port state alone
   assign full_rst = SYS_RST_IN | lvp_s2_q;

   // two-flop synchronisers for pins, comparator and supply monitor
   always_ff @(posedge REF_CLK_IN) begin
      pa_s1_q  <= A_PIN_IN;
      pa_s2_q  <= pa_s1_q;
      pb_s1_q  <= B_PIN_IN;
      pb_s2_q  <= pb_s1_q;
      cmp_s1_q <= CMP_RESULT_IN;
      cmp_s2_q <= cmp_s1_q;
      cmp_s3_q <= cmp_s2_q;
      lvp_s1_q <= LOW_SUPPLY_IN;
      lvp_s2_q <= lvp_s1_q;
   end

   // supply trip drives the global reset; no reset term, it is the reset
   always_ff @(posedge REF_CLK_IN) begin
      GLOBAL_RST_OUT <= lvp_s2_q;
   end

   // ahb address decode; only the eight mapped words answer
   always_comb begin
      addr_idx      = HADDR_IN[prcs_pkg::IDX_MSB:prcs_pkg::IDX_LSB];
      addr_hit      = (HADDR_IN[31:prcs_pkg::HI_LSB] == '0) &&
                      (addr_idx[7:prcs_pkg::REGSEL_W] ==
                       prcs_pkg::IDX_PA_IN[7:prcs_pkg::REGSEL_W]);
      phase_d.valid = HSEL_IN & HTRANS_IN[prcs_pkg::HTRANS_ACT] & addr_hit;
      phase_d.write = HWRITE_IN;
      phase_d.word  = (HSIZE_IN == prcs_pkg::HSIZE_WORD);
      phase_d.sel   = prcs_pkg::prcs_reg_type'(addr_idx[prcs_pkg::REGSEL_W-1:0]);
   end

   // address phase capture; zero wait states so hready is the only qualifier
   always_ff @(posedge REF_CLK_IN) begin
      if (full_rst) begin
         phase_q <= '0;
      end else if (HREADY_IN) begin
         phase_q <= phase_d;
      end
   end

   // data phase write strobes; sub-word writes are dropped
   always_comb begin
      wr_fire = phase_q.valid & phase_q.write & phase_q.word & ~full_rst;
      wdata   = HWDATA_IN[prcs_pkg::REG_W-1:0];
      wr_en   = '0;
      if (wr_fire) begin
         wr_en[phase_q.sel] = 1'b1;
      end
   end

   // read mux, forwarding a write in flight so back to back access is coherent
   always_comb begin
      rd_val = '0;
      case (phase_d.sel)
         prcs_pkg::PRCS_PA_IN:   rd_val = ina_q;
         prcs_pkg::PRCS_PA_OUT:  rd_val = outa_q;
         prcs_pkg::PRCS_PA_DIR:  rd_val = dira_q;
         prcs_pkg::PRCS_PA_FSEL: rd_val = fsela_q;
         prcs_pkg::PRCS_PB_IN:   rd_val = {2'h0, inb_q};
         prcs_pkg::PRCS_PB_OUT:  rd_val = {2'h0, outb_q};
         prcs_pkg::PRCS_PB_DIR:  rd_val = {2'h0, dirb_q};
         prcs_pkg::PRCS_PB_FSEL: rd_val = {2'h0, fselb_q};
         default:                rd_val = '0;
      endcase
      if (wr_fire && phase_q.sel == phase_d.sel) begin
         rd_val = wdata;
         if (phase_d.sel[2]) begin
            rd_val[7:PB_W] = '0;
         end
      end
   end

   // read data register, loaded at the accepted address phase
   always_ff @(posedge REF_CLK_IN) begin
      if (full_rst) begin
         rdata_q <= '0;
      end else if (HREADY_IN) begin
         rdata_q <= (phase_d.valid && !phase_d.write) ? {24'h0, rd_val} : 32'h0;
      end
   end

   assign HRDATA_OUT    = rdata_q;
   assign HREADYOUT_OUT = 1'b1;
   assign HRESP_OUT     = 1'b0;

   // output value registers carry no reset so they survive a full reset
   always_ff @(posedge REF_CLK_IN) begin
      if (wr_en[prcs_pkg::PRCS_PA_OUT]) begin
         outa_q <= wdata;
      end
      if (wr_en[prcs_pkg::PRCS_PB_OUT]) begin
         outb_q <= wdata[PB_W-1:0];
      end
   end

   // direction registers
   always_ff @(posedge REF_CLK_IN) begin
      if (full_rst) begin
         dira_q <= prcs_pkg::DIR_RST;
         dirb_q <= prcs_pkg::DIR_RST[PB_W-1:0];
      end else begin
         if (wr_en[prcs_pkg::PRCS_PA_DIR]) begin
            dira_q <= wdata;
         end
         if (wr_en[prcs_pkg::PRCS_PB_DIR]) begin
            dirb_q <= wdata[PB_W-1:0];
         end
      end
   end

   // function select registers; port a bits choose open drain
   always_ff @(posedge REF_CLK_IN) begin
      if (full_rst) begin
         fsela_q <= prcs_pkg::FSEL_RST;
         fselb_q <= prcs_pkg::FSEL_RST[PB_W-1:0];
      end else begin
         if (wr_en[prcs_pkg::PRCS_PA_FSEL]) begin
            fsela_q <= wdata;
         end
         if (wr_en[prcs_pkg::PRCS_PB_FSEL]) begin
            fselb_q <= wdata[PB_W-1:0];
         end
      end
   end

   // comparator select and its stop-mode freeze; the analog block itself
   // decides high when input is above reference, we only sample it
   assign comp_sel = fselb_q[CI] & fselb_q[CR];
   assign cmp_now  = STOP_MODE_IN ? cmp_hold_q : cmp_s2_q;

   // last comparator value is held so a powered down comparator reads stable
   always_ff @(posedge REF_CLK_IN) begin
      if (full_rst) begin
         cmp_hold_q <= 1'b0;
      end else if (!STOP_MODE_IN) begin
         cmp_hold_q <= cmp_s2_q;
      end
   end

   // port b sample: bit 4 replaced by comparator, bit 3 stays the reference pin
   always_comb begin
      cmp_mask     = '0;
      cmp_mask[CI] = comp_sel;
      cmp_mask[CR] = comp_sel;
      samp_b       = pb_s2_q;
      if (comp_sel) begin
         samp_b[CI] = cmp_now;
      end
      in_mask_b    = ~dirb_q | cmp_mask;
   end

   // per-bit input registers; input bits resample every clock, so a software
   // write survives exactly one cycle, output bits keep what was written except b4/b3 while the comparator is selected
   for (genvar i = 0; i < PA_W; i++) begin : g_ina
      always_ff @(posedge REF_CLK_IN) begin
         if (full_rst) begin
            ina_q[i] <= pa_s2_q[i];
         end else if (wr_en[prcs_pkg::PRCS_PA_IN]) begin
            ina_q[i] <= wdata[i];
         end else if (!dira_q[i]) begin
            ina_q[i] <= pa_s2_q[i];
         end
      end
   end

   for (genvar i = 0; i < PB_W; i++) begin : g_inb
      always_ff @(posedge REF_CLK_IN) begin
         if (full_rst) begin
            inb_q[i] <= pb_s2_q[i];
         end else if (wr_en[prcs_pkg::PRCS_PB_IN]) begin
            inb_q[i] <= wdata[i];
         end else if (in_mask_b[i]) begin
            inb_q[i] <= samp_b[i];
         end
      end
   end

   // pin drivers; comparator pins are forced to inputs while selected
   always_ff @(posedge REF_CLK_IN) begin
      if (full_rst) begin
         A_PIN_OUT     <= '0;
         A_PIN_OE_OUT  <= '0;
         B_PIN_OUT     <= '0;
         B_PIN_OE_OUT  <= '0;
         CMP_ROUTE_OUT <= 1'b0;
         CMP_POWER_OUT <= 1'b0;
      end else begin
         A_PIN_OUT     <= outa_q & dira_q;
         A_PIN_OE_OUT  <= dira_q & ~(fsela_q & outa_q);
         B_PIN_OUT     <= outb_q & dirb_q;
         B_PIN_OE_OUT  <= dirb_q & ~cmp_mask;
         CMP_ROUTE_OUT <= comp_sel;
         CMP_POWER_OUT <= comp_sel & ~STOP_MODE_IN;
      end
   end

   // interrupt sources and halt wake; halt leaves the comparator running
   always_ff @(posedge REF_CLK_IN) begin
      if (full_rst) begin
         PB_IRQ_SRC_OUT <= '0;
         HALT_WAKE_OUT  <= 1'b0;
      end else begin
         PB_IRQ_SRC_OUT <= samp_b;
         HALT_WAKE_OUT  <= HALT_MODE_IN & B4_IRQ_EN_IN & comp_sel &
                           cmp_s2_q & ~cmp_s3_q;
      end
   end

   default clocking cb @(posedge REF_CLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   a_reset_dir_clear: assert property (
      $past(full_rst) |-> (dira_q == '0) && (dirb_q == '0))
      else $error("direction not cleared by full reset");

   a_reset_fsel_clear: assert property (
      $past(full_rst) |-> (fsela_q == '0) && (fselb_q == '0) && !CMP_POWER_OUT)
      else $error("function select not cleared by full reset");

   a_reset_out_keep: assert property (
      $past(full_rst) |-> (outa_q === $past(outa_q)) && (outb_q === $past(outb_q)))
      else $error("output value changed across reset");

   a_reset_in_load: assert property (
      $past(full_rst) |-> ina_q == $past(A_PIN_IN, 3))
      else $error("input register not loaded at reset");

   a_input_sync_path: assert property (
      (!$past(wr_en[prcs_pkg::PRCS_PA_IN]) && !$past(full_rst))
      |-> ((ina_q ^ $past(A_PIN_IN, 3)) & ~$past(dira_q)) == '0)
      else $error("input bit not three cycles behind pin");

   a_in_write_lost: assert property (
      wr_en[prcs_pkg::PRCS_PA_IN] && !full_rst ##1 !wr_en[prcs_pkg::PRCS_PA_IN] && !full_rst
      |=> ((ina_q ^ $past(pa_s2_q)) & ~$past(dira_q)) == '0)
      else $error("written input bit not resampled");

   a_output_drive: assert property (
      (fsela_q == '0) && $stable(dira_q) && $stable(outa_q) && !$past(full_rst)
      |-> (A_PIN_OE_OUT == dira_q) && (A_PIN_OUT == (outa_q & dira_q)))
      else $error("pin not driven from output register");

   a_cmp_route_on: assert property (
      $past(comp_sel) && !$past(full_rst)
      |-> CMP_ROUTE_OUT && !B_PIN_OE_OUT[CI] && !B_PIN_OE_OUT[CR])
      else $error("comparator pins not routed");

   a_cmp_in_bit: assert property (
      comp_sel && !STOP_MODE_IN && !wr_en[prcs_pkg::PRCS_PB_IN] && !full_rst
      |=> inb_q[CI] == $past(CMP_RESULT_IN, 3))
      else $error("input bit 4 does not track comparator");

   a_cmp_irq_src: assert property (
      $past(comp_sel) && !$past(STOP_MODE_IN) && !$past(full_rst)
      |-> PB_IRQ_SRC_OUT[CI] == $past(CMP_RESULT_IN, 3))
      else $error("b4 interrupt not from comparator");

   a_cmp_halt_run: assert property (
      comp_sel && HALT_MODE_IN && !STOP_MODE_IN && !full_rst |=> CMP_POWER_OUT)
      else $error("comparator off in halt");

   a_cmp_halt_wake: assert property (
      HALT_MODE_IN && B4_IRQ_EN_IN && comp_sel && !full_rst &&
      $rose(cmp_s2_q) |=> HALT_WAKE_OUT)
      else $error("comparator edge did not wake halt");

   a_cmp_stop_off: assert property (
      STOP_MODE_IN |=> !CMP_POWER_OUT)
      else $error("comparator powered in stop");

   a_low_supply_rst: assert property (
      $past(LOW_SUPPLY_IN, 3) |-> GLOBAL_RST_OUT)
      else $error("low supply did not reset");

endmodule

// *** hw/prcs_pkg.sv ***
// shared constants and types for the port reset and comparator select block
package prcs_pkg;
   // port widths
   localparam int PA_W  = 8;
   localparam int PB_W  = 6;
   localparam int REG_W = 8;

   // register indexes; byte address is four times the index
   localparam logic [7:0] IDX_PA_IN   = 8'hd0;
   localparam logic [7:0] IDX_PA_OUT  = 8'hd1;
   localparam logic [7:0] IDX_PA_DIR  = 8'hd2;
   localparam logic [7:0] IDX_PA_FSEL = 8'hd3;
   localparam logic [7:0] IDX_PB_IN   = 8'hd4;
   localparam logic [7:0] IDX_PB_OUT  = 8'hd5;
   localparam logic [7:0] IDX_PB_DIR  = 8'hd6;
   localparam logic [7:0] IDX_PB_FSEL = 8'hd7;

   // address decode: index sits in haddr[9:2], bits above must be zero
   localparam int IDX_LSB     = 2;
   localparam int IDX_MSB     = 9;
   localparam int REGSEL_W    = 3;
   localparam int HI_LSB      = 10;

   // reset values
   localparam logic [REG_W-1:0] DIR_RST  = 8'h00;
   localparam logic [REG_W-1:0] FSEL_RST = 8'h00;

   // comparator pins on port b
   localparam int CMP_IN_BIT  = 4;
   localparam int CMP_REF_BIT = 3;

   // ahb-lite codes
   localparam logic [2:0] HSIZE_WORD = 3'b010;
   localparam int         HTRANS_ACT = 1;

   // register selector, low three bits of the index
   typedef enum logic [2:0] {
      PRCS_PA_IN   = 3'b000,
      PRCS_PA_OUT  = 3'b001,
      PRCS_PA_DIR  = 3'b010,
      PRCS_PA_FSEL = 3'b011,
      PRCS_PB_IN   = 3'b100,
      PRCS_PB_OUT  = 3'b101,
      PRCS_PB_DIR  = 3'b110,
      PRCS_PB_FSEL = 3'b111
   } prcs_reg_type;

   // captured ahb address phase
   typedef struct packed {
      logic         valid;
      logic         write;
      logic         word;
      prcs_reg_type sel;
   } prcs_phase_type;
endpackage

// *** bench/prcs_pins.sv ***
// external pin and analog comparator model facing the port block
`timescale 1ns/10ps
module prcs_pins (
   input  wire logic       clk_in,    // system clock
   input  wire logic [7:0] a_ext_in,  // level others put on port a
   input  wire logic [5:0] b_ext_in,  // level others put on port b
   input  wire logic [7:0] ain_in,    // analog level on the comparator input pin
   input  wire logic [7:0] aref_in,   // analog level on the comparator reference pin
   input  wire logic [7:0] a_drv_in,  // block drive value, port a
   input  wire logic [7:0] a_oe_in,   // block drive enable, port a
   input  wire logic [5:0] b_drv_in,  // block drive value, port b
   input  wire logic [5:0] b_oe_in,   // block drive enable, port b
   input  wire logic       route_in,  // pins routed to the comparator
   input  wire logic       power_in,  // comparator bias on
   output logic [7:0]      a_pin_out, // resolved port a wire levels
   output logic [5:0]      b_pin_out, // resolved port b wire levels
   output logic            cmp_out    // comparator output
);
   logic cmp_last = 1'b0;

   // the block wins where it drives; an enable not yet settled at power-up
   // leaves the pad to the outside level, as an undriven pad would
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         a_pin_out[i] = (a_oe_in[i] === 1'b1) ? a_drv_in[i] : a_ext_in[i];
      end
      for (int i = 0; i < 6; i++) begin
         b_pin_out[i] = (b_oe_in[i] === 1'b1) ? b_drv_in[i] : b_ext_in[i];
      end
   end

   // an unpowered or unrouted comparator gives no trustworthy level, so it toggles
   always_comb begin
      if (power_in && route_in) begin
         cmp_out = (ain_in > aref_in);
      end else begin
         cmp_out = ~cmp_last;
      end
   end

   // remember the last level for the toggling idle pattern
   always_ff @(posedge clk_in) begin
      cmp_last <= cmp_out;
   end
endmodule

// *** bench/tb.sv ***
// self-checking bench for the port reset and comparator select block
`timescale 1ns/10ps
module tb;
   logic        clk   = 1'b0;
   logic        rst   = 1'b1;
   logic        hsel  = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hrdy;
   logic        hresp;
   logic [7:0]  a_ext = 8'h3c;
   logic [5:0]  b_ext = 6'h25;
   logic [7:0]  ain   = 8'h20;
   logic [7:0]  aref  = 8'h50;
   logic        halt  = 1'b0;
   logic        stop  = 1'b0;
   logic        irq_en = 1'b0;
   logic        low_sup = 1'b0;
   logic [7:0]  a_pin, a_drv, a_oe;
   logic [5:0]  b_pin, b_drv, b_oe, irq_src;
   logic        cmp_w, route, power, wake, grst;
   logic        rd_ph = 1'b0;
   logic [31:0] exp_q[$];
   logic [31:0] wake_cnt = 32'h0;
   logic [31:0] w0;
   logic [31:0] lfsr_q = 32'h90ec;
   logic [7:0]  dirv, outv, swv;
   int          mismatches = 0;
   int          checks_done = 0;

   // clock at 200 mhz
   always #2.5 clk = ~clk;

   prcs_gpio dut (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
      .HREADY_IN(hrdy), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp),
      .A_PIN_IN(a_pin), .A_PIN_OUT(a_drv), .A_PIN_OE_OUT(a_oe), .B_PIN_IN(b_pin),
      .B_PIN_OUT(b_drv), .B_PIN_OE_OUT(b_oe), .CMP_RESULT_IN(cmp_w), .CMP_ROUTE_OUT(route),
      .CMP_POWER_OUT(power), .HALT_MODE_IN(halt), .STOP_MODE_IN(stop),
      .B4_IRQ_EN_IN(irq_en), .PB_IRQ_SRC_OUT(irq_src), .HALT_WAKE_OUT(wake),
      .LOW_SUPPLY_IN(low_sup), .GLOBAL_RST_OUT(grst));

   prcs_pins pins (.clk_in(clk), .a_ext_in(a_ext), .b_ext_in(b_ext), .ain_in(ain),
      .aref_in(aref), .a_drv_in(a_drv), .a_oe_in(a_oe), .b_drv_in(b_drv), .b_oe_in(b_oe),
      .route_in(route), .power_in(power), .a_pin_out(a_pin), .b_pin_out(b_pin),
      .cmp_out(cmp_w));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      if (mismatches == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // address phase held until hready is seen high, then the bus goes idle
   task automatic bus_addr(input logic [7:0] idx, input logic wr_en);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {22'h0, idx, 2'b00};
      hwrite <= wr_en;
      hsize  <= prcs_pkg::HSIZE_WORD;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] data);
      bus_addr(idx, 1'b1);
      hwdata <= data;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
   endtask

   // the expected word is noted first; the monitor compares it at the data edge
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      exp_q.push_back(exp);
      bus_addr(idx, 1'b0);
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
   endtask

   // monitor: a read data phase completes on an edge with hready high
   always @(posedge clk) begin
      if (rd_ph && hrdy === 1'b1 && exp_q.size() > 0) begin
         check(hrdata, exp_q.pop_front());
      end
      if (hrdy === 1'b1) begin
         rd_ph <= hsel && htrans[1] && !hwrite;
      end
   end

   // wake pulses are counted so one rising comparator edge gives exactly one
   always @(posedge clk) begin
      if (wake === 1'b1) begin
         wake_cnt <= wake_cnt + 32'h1;
      end
   end

   // watchdog sized well beyond the couple of hundred cycles the sequence needs
   initial begin
      #100000;
      mismatches++;
      close_out();
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(prcs_pkg::IDX_PA_DIR, 32'h0);
      rd(prcs_pkg::IDX_PB_DIR, 32'h0);
      rd(prcs_pkg::IDX_PA_FSEL, 32'h0);
      rd(prcs_pkg::IDX_PB_FSEL, 32'h0);
      rd(prcs_pkg::IDX_PA_IN, {24'h0, a_ext});
      rd(prcs_pkg::IDX_PB_IN, {26'h0, b_ext});
      // random directions and values; input bits of output pins keep what software wrote
      for (int i = 0; i < 4; i++) begin
         lfsr_q = lfsr_next(lfsr_q);
         dirv = lfsr_q[7:0];
         outv = lfsr_q[15:8];
         swv  = lfsr_q[23:16];
         a_ext <= lfsr_q[31:24];
         wr(prcs_pkg::IDX_PA_OUT, {24'h0, outv});
         wr(prcs_pkg::IDX_PB_OUT, {26'h0, outv[5:0]});
         wr(prcs_pkg::IDX_PA_DIR, {24'h0, dirv});
         wr(prcs_pkg::IDX_PA_IN, {24'h0, swv});
         repeat (4) @(posedge clk);
         #1;
         check({24'h0, a_oe}, {24'h0, dirv});
         check({24'h0, a_drv}, {24'h0, outv & dirv});
         @(posedge clk);
         rd(prcs_pkg::IDX_PA_IN, {24'h0, (swv & dirv) | (a_ext & ~dirv)});
         rd(prcs_pkg::IDX_PA_OUT, {24'h0, outv});
      end
      // a second full reset keeps output values, clears directions, reloads inputs
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(prcs_pkg::IDX_PA_OUT, {24'h0, outv});
      rd(prcs_pkg::IDX_PA_DIR, 32'h0);
      rd(prcs_pkg::IDX_PA_IN, {24'h0, a_ext});
      // select is cleared first and set last; pin b4 shows the digital level opposite to the comparator, b3 the same level
      wr(prcs_pkg::IDX_PB_FSEL, 32'h0);
      wr(prcs_pkg::IDX_PB_DIR, 32'h0);
      wr(prcs_pkg::IDX_PB_FSEL, 32'h18);
      for (int k = 0; k < 2; k++) begin
         ain   <= (k == 0) ? 8'h90 : 8'h20;
         b_ext <= (k == 0) ? 6'h08 : 6'h10;
         repeat (5) @(posedge clk);
         #1;
         check({31'h0, irq_src[4]}, (k == 0) ? 32'h1 : 32'h0);
         check({30'h0, route, power}, 32'h3);
         @(posedge clk);
         rd(prcs_pkg::IDX_PB_IN, (k == 0) ? 32'h18 : 32'h0);
      end
      // halt: a rising comparator wakes the core only while the b4 interrupt is enabled
      halt   <= 1'b1;
      irq_en <= 1'b1;
      repeat (6) @(posedge clk);
      w0 = wake_cnt;
      ain <= 8'h90;
      repeat (10) @(posedge clk);
      check(wake_cnt - w0, 32'h1);
      rd(prcs_pkg::IDX_PB_IN, 32'h10);
      irq_en <= 1'b0;
      ain    <= 8'h20;
      repeat (6) @(posedge clk);
      w0 = wake_cnt;
      ain <= 8'h90;
      repeat (10) @(posedge clk);
      check(wake_cnt - w0, 32'h0);
      halt <= 1'b0;
      // stop powers the comparator down but keeps the selection
      stop <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check({30'h0, route, power}, 32'h2);
      @(posedge clk);
      stop <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check({31'h0, power}, 32'h1);
      @(posedge clk);
      // a low supply acts as a full reset and is passed on as the global reset
      wr(prcs_pkg::IDX_PB_DIR, 32'h01);
      low_sup <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      check({31'h0, grst}, 32'h1);
      @(posedge clk);
      low_sup <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      check({30'h0, grst, route}, 32'h0);
      @(posedge clk);
      rd(prcs_pkg::IDX_PB_DIR, 32'h0);
      rd(prcs_pkg::IDX_PB_FSEL, 32'h0);
      rd(prcs_pkg::IDX_PB_OUT, {26'h0, outv[5:0]});
      // an unmapped word ignores writes and reads zero with an okay response
      wr(8'hd8, 32'hffff_ffff);
      rd(8'hd8, 32'h0);
      repeat (2) @(posedge clk);
      check({31'h0, hresp}, 32'h0);
      check(exp_q.size(), 32'h0);
      close_out();
   end
endmodule
